// [logic/itw_pkg.sv]
package itw_pkg;
    // Register byte addresses on the APB slave.
    localparam logic [7:0] IRQ_FLAGS_IDX = 8'h3f;
    localparam logic [11:0] ADDR_IRQ_FLAGS = {2'b00, IRQ_FLAGS_IDX, 2'b00};
    localparam logic [11:0] ADDR_CORE_CTRL = 12'h000;
    localparam logic [11:0] ADDR_WDT_SLEEP = 12'h004;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h008;
    localparam logic [11:0] ADDR_TIMER = 12'h00c;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    localparam logic [11:0] ADDR_INSTR = 12'h014;
    localparam logic [11:0] ADDR_EVENTS = 12'h018;
    // Field positions.
    localparam int FLAG_TIMER = 0;
    localparam int FLAG_EXT = 1;
    localparam int FLAG_SERIAL = 2;
    localparam int FLAG_TMR2 = 3;
    localparam int CTRL_RATIO_LSB = 0;
    localparam int CTRL_ASSIGN = 3;
    localparam int CTRL_GIE = 6;
    localparam int CTRL_PULLUP_N = 7;
    localparam int WS_WAKE_EN_N = 0;
    localparam int WS_ROPT = 3;
    localparam int WS_SLEEP_CTRL = 4;
    localparam int WS_WDT_EN = 5;
    localparam int WS_OPEN_DRAIN = 6;
    localparam int ST_POWER_DOWN = 3;
    localparam int ST_TIME_OUT = 4;
    localparam int INS_WDT_CLEAR = 0;
    localparam int INS_SLEEP = 1;
    localparam int INS_DISABLE = 2;
    localparam int INS_ENABLE = 3;
    localparam int INS_RETURN = 4;
    // Writable bit masks and reset values.
    localparam logic [7:0] CTRL_WMASK = 8'h8f;
    localparam logic [7:0] WS_WMASK = 8'h79;
    localparam logic [7:0] MASK_WMASK = 8'h0f;
    localparam logic [7:0] CTRL_RESET = 8'h3f;
    localparam logic [7:0] WS_RESET = 8'h01;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    // Timing.
    localparam int CLK_MHZ = 100;
    localparam int WDT_PERIOD_US = 18000;
    localparam int OST_DELAY_US = 18000;
    localparam int WDT_CYCLES = WDT_PERIOD_US * CLK_MHZ;
    localparam int OST_CYCLES = OST_DELAY_US * CLK_MHZ;
    localparam int WDT_TICK_DIV = 8;
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_SLEEP = 2'b01,
        PWR_START = 2'b10
    } itw_pwr_e;
endpackage

// [logic/itw_sync.sv]
`timescale 1ns/10ps
// Three-stage synchroniser; a change is accepted once stages two and three agree.
module itw_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic [2:0] sh_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_q <= 3'h7;
            dout <= 1'b1;
        end else begin
            sh_q <= {sh_q[1:0], din};
            if (sh_q[1] == sh_q[2]) begin
                dout <= sh_q[2];
            end
        end
    end
endmodule // itw_sync

// [logic/itw_prescaler.sv]
`timescale 1ns/10ps
// Shared 8-bit prescaler; tick pulses once per 2^shift input ticks.
module itw_prescaler (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic step,
    input wire logic [3:0] shift,
    output logic tick,
    output logic [7:0] count
);
    logic [8:0] nxt;
    assign nxt = {1'b0, count} + 9'h001;
    always_comb begin
        if (shift == 4'h0) begin
            tick = step;
        end else begin
            tick = step && ((nxt & ((9'h001 << shift) - 9'h001)) == 9'h000);
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
        end else if (clear) begin
            count <= 8'h00;
        end else if (step) begin
            count <= nxt[7:0];
        end
    end
endmodule // itw_prescaler

// [logic/itw_core.sv]
`timescale 1ns/10ps
// Overview of operation
// - Timer overflow sets the timer flag; it stays until software clears it.
// - A falling edge on the external pin sets the external flag.
// - Serial transfer completion sets the serial flag; software alone clears it.
// - The second timer's match sets its flag; software alone clears it.
// - Writes to the flag register only clear flags; upper bits read zero.
// - Reading the flag register returns flags ANDed with the mask.
// - Each source enabled by its mask bit and the global enable; mask is read/write.
// - Global enable cleared by disable, set by enable or return instruction.
// - Assignment bit routes the prescaler to timer (0) or watchdog (1).
// - Ratio bits give timer 1:2 to 1:256 and watchdog 1:1 to 1:128.
// - Control bits 0-3 and 7 are read/write; bits 4-5 read zero.
// - Prescaler is 8 bits; a timer write clears it when assigned to timer.
// - Watchdog clear and sleep clear the watchdog and its assigned prescaler.
// - The timer counts every cycle, or once per prescaler period.
// - Watchdog runs during sleep; an enabled time-out resets the device.
// - Watchdog enable bit works only when the build option is set.
// - Wake-up falling edge sets sleep control; its falls and rises sleep and wake.
// - After wake, execution waits about 18 ms before resuming.
// - Wake-up enable bit is active low and read/write.
// - Status power-down and time-out bits follow power-on, clear, sleep, time-out.
module itw_core #(
    parameter int WDT_CYC = itw_pkg::WDT_CYCLES,
    parameter int OST_CYC = itw_pkg::OST_CYCLES,
    parameter bit WDT_OPTION = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_n,
    input wire logic wakeup_n,
    input wire logic serial_done,
    input wire logic second_timer_match,
    output logic irq,
    output logic core_hold,
    output logic osc_stopped,
    output logic wdt_reset,
    output logic [7:0] timer_value
);
    logic rst_s1_q;
    logic rst_n;
    logic ext_s;
    logic wake_s;
    logic ext_prev_q;
    logic wake_prev_q;
    logic [3:0] flags_q;
    logic [3:0] mask_q;
    logic [7:0] ctrl_q;
    logic [7:0] ws_q;
    logic [7:0] status_q;
    logic [7:0] timer_q;
    logic [4:0] instr;
    logic [31:0] wdt_q;
    logic [31:0] ost_q;
    logic [2:0] wdt_div_q;
    itw_pkg::itw_pwr_e pwr_q;
    logic wr;
    logic [3:0] flag_set;
    logic [7:0] wb;
    logic wdt_on;
    logic wdt_expire;
    logic ps_clear;
    logic ps_step;
    logic [3:0] ps_shift;
    logic ps_tick;
    logic timer_step;
    logic wdt_step;
    logic sleep_fall;
    logic sleep_rise;
    logic [7:0] ws_next;
    logic [31:0] rdata_d;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    itw_sync u_sync_ext (
        .clk(ref_clk),
        .rst_n(rst_n),
        .din(ext_irq_n),
        .dout(ext_s)
    );
    itw_sync u_sync_wake (
        .clk(ref_clk),
        .rst_n(rst_n),
        .din(wakeup_n),
        .dout(wake_s)
    );

    // Zero-wait slave: every access completes in its first access cycle.
    // Writes commit only at the edge where the master samples pready high.
    assign wr = psel && penable && pwrite && pready;
    assign wb = pstrb[0] ? pwdata[7:0] : 8'h00;
    assign instr = (wr && paddr == itw_pkg::ADDR_INSTR && pstrb[0]) ? pwdata[4:0] : 5'h00;

    assign wdt_on = WDT_OPTION && ws_q[itw_pkg::WS_WDT_EN] && pwr_q != itw_pkg::PWR_START;

    assign ps_step = ctrl_q[itw_pkg::CTRL_ASSIGN] ? wdt_step : 1'b1;
    assign ps_shift = ctrl_q[itw_pkg::CTRL_ASSIGN] ? {1'b0, ctrl_q[2:0]}
                                                   : {1'b0, ctrl_q[2:0]} + 4'h1;
    // watchdog clear and sleep clear assigned prescaler
    assign ps_clear = (!ctrl_q[itw_pkg::CTRL_ASSIGN] && wr && paddr == itw_pkg::ADDR_TIMER)
        || (ctrl_q[itw_pkg::CTRL_ASSIGN]
            && (instr[itw_pkg::INS_WDT_CLEAR] || instr[itw_pkg::INS_SLEEP]));

    itw_prescaler u_presc (
        .clk(ref_clk),
        .rst_n(rst_n),
        .clear(ps_clear),
        .step(ps_step),
        .shift(ps_shift),
        .tick(ps_tick),
        .count()
    );

    assign timer_step = ctrl_q[itw_pkg::CTRL_ASSIGN] ? (pwr_q == itw_pkg::PWR_RUN)
                                                     : (ps_tick && pwr_q == itw_pkg::PWR_RUN);
    assign wdt_step = wdt_div_q == 3'h7;
    // A clear in the expiry cycle wins, so just-in-time servicing does not reset.
    assign wdt_expire = wdt_on && (ctrl_q[itw_pkg::CTRL_ASSIGN] ? ps_tick : wdt_step)
        && wdt_q >= WDT_CYC / itw_pkg::WDT_TICK_DIV - 1
        && !instr[itw_pkg::INS_WDT_CLEAR] && !instr[itw_pkg::INS_SLEEP];

    // Free-running watchdog time base; it keeps counting while the core sleeps.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_div_q <= 3'h0;
        end else begin
            wdt_div_q <= wdt_div_q + 3'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_q <= 32'h0000_0000;
            wdt_reset <= 1'b0;
        end else begin
            wdt_reset <= wdt_expire;
            if (instr[itw_pkg::INS_WDT_CLEAR] || instr[itw_pkg::INS_SLEEP] || !wdt_on
                || wdt_expire) begin
                wdt_q <= 32'h0000_0000;
            end else if (ctrl_q[itw_pkg::CTRL_ASSIGN] ? ps_tick : wdt_step) begin
                wdt_q <= wdt_q + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_q <= 8'h00;
            timer_value <= 8'h00;
        end else begin
            if (wr && paddr == itw_pkg::ADDR_TIMER) begin
                timer_q <= wb;
            end else if (timer_step) begin
                timer_q <= timer_q + 8'h01;
            end
            timer_value <= timer_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_prev_q <= 1'b1;
            wake_prev_q <= 1'b1;
        end else begin
            ext_prev_q <= ext_s;
            wake_prev_q <= wake_s;
        end
    end

    assign flag_set[itw_pkg::FLAG_TIMER] = timer_step && timer_q == 8'hff;
    assign flag_set[itw_pkg::FLAG_EXT] = ext_prev_q && !ext_s;
    assign flag_set[itw_pkg::FLAG_SERIAL] = serial_done;
    assign flag_set[itw_pkg::FLAG_TMR2] = second_timer_match;

    // Flags: a hardware set in the same cycle as a software clear wins.
    for (genvar g = 0; g < 4; g++) begin : g_flag
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                flags_q[g] <= 1'b0;
            end else if (flag_set[g]) begin
                flags_q[g] <= 1'b1;
            end else if (wr && paddr == itw_pkg::ADDR_IRQ_FLAGS && pstrb[0] && !wb[g]) begin
                flags_q[g] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= 4'h0;
        end else if (wr && paddr == itw_pkg::ADDR_IRQ_MASK && pstrb[0]) begin
            mask_q <= wb[3:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= itw_pkg::CTRL_RESET & itw_pkg::CTRL_WMASK;
        end else begin
            if (wr && paddr == itw_pkg::ADDR_CORE_CTRL && pstrb[0]) begin
                ctrl_q[7] <= wb[itw_pkg::CTRL_PULLUP_N];
                ctrl_q[3:0] <= wb[3:0];
            end
            if (instr[itw_pkg::INS_DISABLE]) begin
                ctrl_q[itw_pkg::CTRL_GIE] <= 1'b0;
            end else if (instr[itw_pkg::INS_ENABLE] || instr[itw_pkg::INS_RETURN]) begin
                ctrl_q[itw_pkg::CTRL_GIE] <= 1'b1;
            end
        end
    end

    // hardware sets sleep control on wake-up falling edge
    always_comb begin
        ws_next = ws_q;
        if (wr && paddr == itw_pkg::ADDR_WDT_SLEEP && pstrb[0]) begin
            ws_next = wb & itw_pkg::WS_WMASK;
        end
        if (wake_prev_q && !wake_s && !ws_q[itw_pkg::WS_WAKE_EN_N]) begin
            ws_next[itw_pkg::WS_SLEEP_CTRL] = 1'b1;
        end
    end
    assign sleep_fall = ws_q[itw_pkg::WS_SLEEP_CTRL] && !ws_next[itw_pkg::WS_SLEEP_CTRL];
    assign sleep_rise = !ws_q[itw_pkg::WS_SLEEP_CTRL] && ws_next[itw_pkg::WS_SLEEP_CTRL];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ws_q <= itw_pkg::WS_RESET | (8'h01 << itw_pkg::WS_SLEEP_CTRL);
        end else begin
            ws_q <= ws_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= itw_pkg::PWR_RUN;
            ost_q <= 32'h0000_0000;
        end else begin
            unique case (pwr_q)
                itw_pkg::PWR_RUN: begin
                    if (sleep_fall) begin
                        pwr_q <= itw_pkg::PWR_SLEEP;
                    end
                end
                itw_pkg::PWR_SLEEP: begin
                    if (sleep_rise) begin
                        pwr_q <= itw_pkg::PWR_START;
                        ost_q <= 32'h0000_0000;
                    end
                end
                itw_pkg::PWR_START: begin
                    if (ost_q >= OST_CYC - 1) begin
                        pwr_q <= itw_pkg::PWR_RUN;
                    end else begin
                        ost_q <= ost_q + 32'h0000_0001;
                    end
                end
                default: pwr_q <= itw_pkg::PWR_RUN;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= itw_pkg::STATUS_RESET;
        end else if (wdt_expire) begin
            status_q[itw_pkg::ST_TIME_OUT] <= 1'b0;
        end else if (instr[itw_pkg::INS_WDT_CLEAR]) begin
            status_q[itw_pkg::ST_POWER_DOWN] <= 1'b1;
            status_q[itw_pkg::ST_TIME_OUT] <= 1'b1;
        end else if (instr[itw_pkg::INS_SLEEP]) begin
            status_q[itw_pkg::ST_POWER_DOWN] <= 1'b0;
            status_q[itw_pkg::ST_TIME_OUT] <= 1'b1;
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (paddr)
            itw_pkg::ADDR_IRQ_FLAGS: rdata_d[3:0] = flags_q & mask_q;
            itw_pkg::ADDR_CORE_CTRL: rdata_d[7:0] = ctrl_q;
            itw_pkg::ADDR_WDT_SLEEP: rdata_d[7:0] = ws_q;
            itw_pkg::ADDR_IRQ_MASK: rdata_d[3:0] = mask_q;
            itw_pkg::ADDR_TIMER: rdata_d[7:0] = timer_q;
            itw_pkg::ADDR_STATUS: rdata_d[7:0] = status_q;
            itw_pkg::ADDR_EVENTS: rdata_d[1:0] = pwr_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == itw_pkg::ADDR_IRQ_FLAGS
                || paddr == itw_pkg::ADDR_CORE_CTRL || paddr == itw_pkg::ADDR_WDT_SLEEP
                || paddr == itw_pkg::ADDR_IRQ_MASK || paddr == itw_pkg::ADDR_TIMER
                || paddr == itw_pkg::ADDR_STATUS || paddr == itw_pkg::ADDR_INSTR
                || paddr == itw_pkg::ADDR_EVENTS);
            if (psel && !penable && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
            core_hold <= 1'b0;
            osc_stopped <= 1'b0;
        end else begin
            irq <= ctrl_q[itw_pkg::CTRL_GIE] && |(flags_q & mask_q);
            core_hold <= pwr_q != itw_pkg::PWR_RUN;
            osc_stopped <= pwr_q == itw_pkg::PWR_SLEEP;
        end
    end
endmodule // itw_core

// [bench/itw_core_sva.sv]
`timescale 1ns/10ps
module itw_core_sva #(
    parameter int WDT_CYC = 64,
    parameter int OST_CYC = 20,
    parameter bit WDT_OPTION = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic core_hold,
    input wire logic osc_stopped,
    input wire logic wdt_reset
);
    logic mapped;
    logic rd_acc;
    always_comb mapped = paddr inside {itw_pkg::ADDR_IRQ_FLAGS, itw_pkg::ADDR_CORE_CTRL,
        itw_pkg::ADDR_WDT_SLEEP, itw_pkg::ADDR_IRQ_MASK, itw_pkg::ADDR_TIMER,
        itw_pkg::ADDR_STATUS, itw_pkg::ADDR_INSTR, itw_pkg::ADDR_EVENTS};
    assign rd_acc = psel && penable && pready && !pwrite;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("error response wrong");
    a_flags_upper_zero: assert property (rd_acc && paddr == itw_pkg::ADDR_IRQ_FLAGS
        |-> prdata[31:4] == 28'h000_0000)
        else $error("flag upper bits set");
    a_ctrl_gap_zero: assert property (rd_acc && paddr == itw_pkg::ADDR_CORE_CTRL
        |-> prdata[5:4] == 2'b00)
        else $error("control unused bits set");
    a_mask_upper_zero: assert property (rd_acc && paddr == itw_pkg::ADDR_IRQ_MASK
        |-> prdata[7:4] == 4'h0)
        else $error("mask upper bits set");
    a_disable_drops_irq: assert property (psel && penable && pready && pwrite
        && paddr == itw_pkg::ADDR_INSTR && pwdata[2] && !pwdata[3] && !pwdata[4]
        |-> ##[1:3] !irq)
        else $error("irq kept after disable");
    a_sleep_holds: assert property (osc_stopped |-> core_hold)
        else $error("execution during sleep");
    a_startup_hold: assert property ($fell(osc_stopped) |-> core_hold [*8])
        else $error("start-up delay too short");
    a_wdt_pulse: assert property (wdt_reset |=> !wdt_reset)
        else $error("watchdog pulse too long");
endmodule // itw_core_sva

bind itw_core itw_core_sva #(.WDT_CYC(WDT_CYC), .OST_CYC(OST_CYC), .WDT_OPTION(WDT_OPTION))
    u_itw_core_sva (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .core_hold(core_hold), .osc_stopped(osc_stopped),
    .wdt_reset(wdt_reset));

// [bench/itw_src_model.sv]
`timescale 1ns/10ps
module itw_src_model (
    input wire logic ref_clk,
    output logic ext_irq_n,
    output logic wakeup_n,
    output logic serial_done,
    output logic second_timer_match
);
    initial begin
        ext_irq_n = 1'b1;
        wakeup_n = 1'b1;
        serial_done = 1'b0;
        second_timer_match = 1'b0;
    end
    // Pins stay low for several cycles so that the input synchroniser sees each edge.
    task automatic fire(input logic [3:0] sel);
        @(posedge ref_clk);
        wakeup_n <= ~sel[0];
        ext_irq_n <= ~sel[1];
        serial_done <= sel[2];
        second_timer_match <= sel[3];
        @(posedge ref_clk);
        serial_done <= 1'b0;
        second_timer_match <= 1'b0;
        repeat (5) @(posedge ref_clk);
        wakeup_n <= 1'b1;
        ext_irq_n <= 1'b1;
    endtask
endmodule // itw_src_model

// [bench/irq_timer_watchdog_control_tb.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module irq_timer_watchdog_control_tb;
    localparam int WDT_CYC = 64;
    localparam int OST_CYC = 20;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, core_hold, osc_stopped, wdt_reset;
    logic ext_irq_n, wakeup_n, serial_done, second_timer_match;
    logic [7:0] timer_value;
    logic [31:0] rd;
    logic err;
    logic [7:0] t0;
    int n_mismatch = 0;
    int checked = 0;
    int n_wdt = 0;
    int n_ost = 0;
    int n;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (wdt_reset === 1'b1) n_wdt++;
    always @(posedge ref_clk) if (core_hold === 1'b1 && osc_stopped === 1'b0) n_ost++;
    itw_core #(.WDT_CYC(WDT_CYC), .OST_CYC(OST_CYC), .WDT_OPTION(1'b1)) u_itw_core (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_n(ext_irq_n), .wakeup_n(wakeup_n),
        .serial_done(serial_done), .second_timer_match(second_timer_match), .irq(irq),
        .core_hold(core_hold), .osc_stopped(osc_stopped), .wdt_reset(wdt_reset),
        .timer_value(timer_value));
    itw_src_model u_itw_src_model (.ref_clk(ref_clk), .ext_irq_n(ext_irq_n),
        .wakeup_n(wakeup_n), .serial_done(serial_done),
        .second_timer_match(second_timer_match));
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        pstrb <= 4'h1;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only the bench watchdog ends a wait for the answer.
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        `CHK(rd, {24'h00_0000, e})
    endtask
    task automatic irq_chk(input logic [11:0] a, input logic [7:0] d, input logic e);
        wr(a, d);
        repeat (3) @(posedge ref_clk);
        `CHK(irq, e)
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rchk(itw_pkg::ADDR_CORE_CTRL, 8'h0f);
        rchk(itw_pkg::ADDR_WDT_SLEEP, 8'h11);
        rchk(itw_pkg::ADDR_IRQ_MASK, 8'h00);
        rchk(itw_pkg::ADDR_IRQ_FLAGS, 8'h00);
        rchk(itw_pkg::ADDR_STATUS, 8'h18);
        xfer(1'b0, 12'h01c, 8'h00);
        `CHK(err, 1'b1)
        wr(itw_pkg::ADDR_CORE_CTRL, 8'hff);
        rchk(itw_pkg::ADDR_CORE_CTRL, 8'h8f);
        wr(itw_pkg::ADDR_CORE_CTRL, 8'h07);
        wr(itw_pkg::ADDR_IRQ_MASK, 8'hff);
        rchk(itw_pkg::ADDR_IRQ_MASK, 8'h0f);
        u_itw_src_model.fire(4'he);
        repeat (4) @(posedge ref_clk);
        rchk(itw_pkg::ADDR_IRQ_FLAGS, 8'h0e);
        wr(itw_pkg::ADDR_IRQ_FLAGS, 8'hff);
        rchk(itw_pkg::ADDR_IRQ_FLAGS, 8'h0e);
        wr(itw_pkg::ADDR_IRQ_FLAGS, 8'hfb);
        wr(itw_pkg::ADDR_IRQ_MASK, 8'h0c);
        rchk(itw_pkg::ADDR_IRQ_FLAGS, 8'h08);
        irq_chk(itw_pkg::ADDR_INSTR, 8'h08, 1'b1);
        irq_chk(itw_pkg::ADDR_INSTR, 8'h04, 1'b0);
        irq_chk(itw_pkg::ADDR_INSTR, 8'h10, 1'b1);
        irq_chk(itw_pkg::ADDR_CORE_CTRL, 8'h07, 1'b1);
        irq_chk(itw_pkg::ADDR_IRQ_MASK, 8'h04, 1'b0);
        irq_chk(itw_pkg::ADDR_IRQ_MASK, 8'h0f, 1'b1);
        irq_chk(itw_pkg::ADDR_IRQ_FLAGS, 8'h00, 1'b0);
        wr(itw_pkg::ADDR_INSTR, 8'h04);
        wr(itw_pkg::ADDR_INSTR, 8'h02);
        rchk(itw_pkg::ADDR_STATUS, 8'h10);
        wr(itw_pkg::ADDR_INSTR, 8'h01);
        rchk(itw_pkg::ADDR_STATUS, 8'h18);
        wr(itw_pkg::ADDR_CORE_CTRL, 8'h08);
        xfer(1'b0, itw_pkg::ADDR_TIMER, 8'h00);
        t0 = rd[7:0];
        xfer(1'b0, itw_pkg::ADDR_TIMER, 8'h00);
        `CHK(rd[7:0], t0 + 8'h03)
        // Reads are spaced by whole prescaler periods so the phase does not matter.
        for (int c = 0; c < 4; c++) begin
            wr(itw_pkg::ADDR_CORE_CTRL, c[7:0]);
            xfer(1'b0, itw_pkg::ADDR_TIMER, 8'h00);
            t0 = rd[7:0];
            repeat ((8 << c) - 3) @(posedge ref_clk);
            xfer(1'b0, itw_pkg::ADDR_TIMER, 8'h00);
            `CHK(rd[7:0], t0 + 8'h04)
        end
        // A timer write restarts the prescaler, so the first 1:8 tick lands on a known edge.
        wr(itw_pkg::ADDR_CORE_CTRL, 8'h02);
        wr(itw_pkg::ADDR_TIMER, 8'h00);
        repeat (8) @(posedge ref_clk);
        `CHK(timer_value, 8'h00)
        repeat (3) @(posedge ref_clk);
        `CHK(timer_value, 8'h01)
        wr(itw_pkg::ADDR_CORE_CTRL, 8'h08);
        wr(itw_pkg::ADDR_IRQ_FLAGS, 8'h00);
        wr(itw_pkg::ADDR_TIMER, 8'hf0);
        repeat (20) @(posedge ref_clk);
        rchk(itw_pkg::ADDR_IRQ_FLAGS, 8'h01);
        wr(itw_pkg::ADDR_WDT_SLEEP, 8'h00);
        repeat (3) @(posedge ref_clk);
        `CHK(osc_stopped, 1'b1)
        n_ost = 0;
        u_itw_src_model.fire(4'h1);
        n = 0;
        while (core_hold !== 1'b0 && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(n_ost >= OST_CYC - 2 && n_ost <= OST_CYC + 4, 1'b1)
        rchk(itw_pkg::ADDR_WDT_SLEEP, 8'h10);
        repeat (150) @(posedge ref_clk);
        `CHK(n_wdt, 0)
        wr(itw_pkg::ADDR_WDT_SLEEP, 8'h30);
        repeat (5) begin
            wr(itw_pkg::ADDR_INSTR, 8'h01);
            repeat (30) @(posedge ref_clk);
        end
        `CHK(n_wdt, 0)
        wr(itw_pkg::ADDR_INSTR, 8'h01);
        n = 0;
        while (n_wdt == 0 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(n >= WDT_CYC - 10 && n <= WDT_CYC + 10, 1'b1)
        complete_run();
    end
endmodule // irq_timer_watchdog_control_tb
